//--- rtl/alarm_compare.sv
// Field comparator for one alarm under its match-select code
`timescale 1ns/1ns
module alarm_compare
    import alarm_match_pkg::*;
(
    // Running time and stored values
    input  time_s      time_in,
    input  alarm_ext_s ext_in,
    input  logic [5:0] hours_in,
    input  logic [2:0] weekday_in,
    input  logic [5:0] date_in,
    input  logic [2:0] select_in,
    // Result
    output logic       match_out
);

    logic sec_eq;
    logic min_eq;
    logic hour_eq;
    logic day_eq;
    logic date_eq;
    logic month_eq;

    // AM/PM bit sits inside the compared hour field, so 12-hour time matches correctly
    assign sec_eq   = time_in.seconds == ext_in.seconds;
    assign min_eq   = time_in.minutes == ext_in.minutes;
    assign hour_eq  = time_in.hours[HOURS_HI:0] == hours_in;
    assign day_eq   = time_in.weekday == weekday_in;
    assign date_eq  = time_in.date == date_in;
    assign month_eq = time_in.month == ext_in.month;

    // Reserved codes never match, a safe answer to a forbidden setting
    always_comb
    begin
        case (select_in)
            SEL_SECONDS: match_out = sec_eq;
            SEL_MINUTES: match_out = min_eq;
            SEL_HOURS:   match_out = hour_eq;
            SEL_WEEKDAY: match_out = day_eq;
            SEL_DATE:    match_out = date_eq;
            SEL_ALL:     match_out = sec_eq & min_eq & hour_eq & day_eq & date_eq & month_eq;
            default:     match_out = 1'b0;
        endcase
    end

endmodule // alarm_compare

//--- rtl/alarm_match_pkg.sv
// Shared constants, field layouts and carrier types for the two calendar alarms
package alarm_match_pkg;

    // Register byte addresses, alarm 0 then alarm 1
    localparam logic [7:0] HOURS_ADDR0   = 8'h0C;
    localparam logic [7:0] WEEKDAY_ADDR0 = 8'h0D;
    localparam logic [7:0] DATE_ADDR0    = 8'h0E;
    localparam logic [7:0] HOURS_ADDR1   = 8'h13;
    localparam logic [7:0] WEEKDAY_ADDR1 = 8'h14;
    localparam logic [7:0] DATE_ADDR1    = 8'h15;

    // Reset values of the stored match fields
    localparam logic [5:0] HOURS_RESET   = 6'h00;
    localparam logic [2:0] WEEKDAY_RESET = 3'h1;
    localparam logic [5:0] DATE_RESET    = 6'h01;
    localparam logic [2:0] SELECT_RESET  = 3'h0;

    // Field positions in the weekday and control register
    localparam int POLARITY_BIT = 7;
    localparam int SELECT_HI    = 6;
    localparam int SELECT_LO    = 4;
    localparam int FLAG_BIT     = 3;
    localparam int WEEKDAY_HI   = 2;
    // Hours keeps AM/PM and both digits; date keeps both digits
    localparam int HOURS_HI     = 5;
    localparam int FORMAT_BIT   = 6;
    localparam int DATE_HI      = 5;
    localparam int UNITS        = 2;

    // Match-select codes
    localparam logic [2:0] SEL_SECONDS = 3'h0;
    localparam logic [2:0] SEL_MINUTES = 3'h1;
    localparam logic [2:0] SEL_HOURS   = 3'h2;
    localparam logic [2:0] SEL_WEEKDAY = 3'h3;
    localparam logic [2:0] SEL_DATE    = 3'h4;
    localparam logic [2:0] SEL_ALL     = 3'h7;

    typedef enum logic [1:0] {KIND_NONE, KIND_HOURS, KIND_WEEKDAY, KIND_DATE} reg_kind_e;

    // Running time counters, BCD as in the timekeeping registers
    typedef struct packed {
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic [6:0] hours;     // Bit 6 is the 12/24 format, bits 5:0 compared
        logic [2:0] weekday;
        logic [5:0] date;
        logic [4:0] month;
    } time_s;

    // Alarm match values kept by the neighbouring seconds/minutes/month registers
    typedef struct packed {
        logic [6:0] seconds;
        logic [6:0] minutes;
        logic [4:0] month;
    } alarm_ext_s;

    // Register kind for an address
    function automatic reg_kind_e reg_kind(input logic [7:0] addr);
        case (addr)
            HOURS_ADDR0, HOURS_ADDR1:     reg_kind = KIND_HOURS;
            WEEKDAY_ADDR0, WEEKDAY_ADDR1: reg_kind = KIND_WEEKDAY;
            DATE_ADDR0, DATE_ADDR1:       reg_kind = KIND_DATE;
            default:                      reg_kind = KIND_NONE;
        endcase
    endfunction

    // Alarm unit addressed, meaningful only when the kind is not none
    function automatic logic reg_unit(input logic [7:0] addr);
        reg_unit = (addr == HOURS_ADDR1) || (addr == WEEKDAY_ADDR1) || (addr == DATE_ADDR1);
    endfunction

endpackage

//--- rtl/rtc_alarm_match.sv
// Two calendar alarms: match registers, sticky flags and the alarm drive of the output pin
`timescale 1ns/1ns

module rtc_alarm_match
    import alarm_match_pkg::*;
(
    // Clock and reset
    input  logic       clock_in,
    input  logic       rst_in,
    // Register port
    input  logic [7:0] reg_addr_in,
    input  logic [7:0] reg_wdata_in,
    input  logic       reg_write_in,
    input  logic       reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Timekeeping
    input  logic       time_advance_in,
    input  time_s      time_in,
    input  alarm_ext_s alarm0_ext_in,
    input  alarm_ext_s alarm1_ext_in,
    // Control bits
    input  logic [1:0] alarm_unit_enable_in,
    input  logic       square_wave_enable_in,
    // Status and multi-function pin
    output logic [1:0] alarm_match_flag_out,
    output logic       alarm_mode_out,
    output logic       multi_function_pin_out,
    output logic       multi_function_pin_oe_n_out
);

    typedef struct packed {
        logic [UNITS-1:0][5:0] hours;
        logic [UNITS-1:0][2:0] select;
        logic [UNITS-1:0][2:0] weekday;
        logic [UNITS-1:0][5:0] date;
        logic [UNITS-1:0]      flag;
        logic [UNITS-1:0]      held;     // Match seen at the last counter advance
        logic                  polarity;
        logic [7:0]            rdata;
        logic                  mode;
        logic                  pin;
        logic                  pin_oe_n;
    } state_s;

    state_s                 state;
    state_s                 next_state;
    logic [1:0]             match;
    reg_kind_e              kind;
    logic                   unit;
    alarm_ext_s [UNITS-1:0] ext;

    // One comparator per alarm, each with its own seconds/minutes/month values
    assign ext = {alarm1_ext_in, alarm0_ext_in};
    for (genvar g = 0; g < UNITS; g++)
    begin : cmp_g
        alarm_compare u_cmp (
            .time_in    (time_in),
            .ext_in     (ext[g]),
            .hours_in   (state.hours[g]),
            .weekday_in (state.weekday[g]),
            .date_in    (state.date[g]),
            .select_in  (state.select[g]),
            .match_out  (match[g])
        );
    end

    assign kind = reg_kind(reg_addr_in);
    assign unit = reg_unit(reg_addr_in);

    // Next state: writes, flag update, readback and pin
    always_comb
    begin
        logic [1:0] active;
        logic       level;
        next_state = state;
        active     = 2'h0;
        level      = 1'b0;
        for (int u = 0; u < UNITS; u++)
        begin
            logic wr;
            logic set;
            wr  = reg_write_in && (unit == u[0]);
            set = 1'b0;
            if (wr && kind == KIND_HOURS)
                next_state.hours[u] = reg_wdata_in[HOURS_HI:0];
            if (wr && kind == KIND_WEEKDAY)
            begin
                next_state.select[u]  = reg_wdata_in[SELECT_HI:SELECT_LO];
                next_state.weekday[u] = reg_wdata_in[WEEKDAY_HI:0];
            end
            if (wr && kind == KIND_DATE)
                next_state.date[u] = reg_wdata_in[DATE_HI:0];
            // Held match follows each counter advance, gated by the unit enable
            if (time_advance_in)
                next_state.held[u] = match[u] & alarm_unit_enable_in[u];
            set = alarm_unit_enable_in[u] & (time_advance_in ? match[u] : state.held[u]);
            // Set beats the write clear; the written flag bit itself is never stored
            if (set)
                next_state.flag[u] = 1'b1;
            else if (wr && kind == KIND_WEEKDAY)
                next_state.flag[u] = 1'b0;
            active[u] = state.flag[u] & alarm_unit_enable_in[u];
        end
        // Polarity is one bit shared by both weekday registers
        if (reg_write_in && kind == KIND_WEEKDAY)
            next_state.polarity = reg_wdata_in[POLARITY_BIT];
        if (reg_read_in)
        begin
            case (kind)
                KIND_HOURS:   next_state.rdata = {1'b0, time_in.hours[FORMAT_BIT], state.hours[unit]};
                KIND_WEEKDAY: next_state.rdata = {state.polarity, state.select[unit], state.flag[unit],
                                                  state.weekday[unit]};
                KIND_DATE:    next_state.rdata = {2'h0, state.date[unit]};
                default:      next_state.rdata = 8'h00;
            endcase
        end
        // Open drain: only a low level is driven, a high level releases the pin
        next_state.mode     = ~square_wave_enable_in & (|alarm_unit_enable_in);
        level               = state.polarity ? (|active) : ~(|active);
        next_state.pin      = 1'b0;
        next_state.pin_oe_n = ~(next_state.mode & ~level);
    end

    // State register
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state          <= '0;
            state.hours    <= {UNITS{HOURS_RESET}};
            state.select   <= {UNITS{SELECT_RESET}};
            state.weekday  <= {UNITS{WEEKDAY_RESET}};
            state.date     <= {UNITS{DATE_RESET}};
            state.pin_oe_n <= 1'b1;
        end
        else
            state <= next_state;
    end

    assign reg_rdata_out               = state.rdata;
    assign alarm_match_flag_out        = state.flag;
    assign alarm_mode_out              = state.mode;
    assign multi_function_pin_out      = state.pin;
    assign multi_function_pin_oe_n_out = state.pin_oe_n;

    // Checks on the flags, the readback and the pin
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Flag set, hold and clear on alarm 0
    match_sets_flag_a: assert property (
        time_advance_in && match[0] && alarm_unit_enable_in[0] |=> alarm_match_flag_out[0])
        else $error("alarm flag not set on match");
    flag_sticky_a: assert property (
        alarm_match_flag_out[0] && !(reg_write_in && kind == KIND_WEEKDAY && !unit) |=> alarm_match_flag_out[0])
        else $error("alarm flag dropped without clear");
    weekday_clear_a: assert property (
        reg_write_in && kind == KIND_WEEKDAY && !unit && !time_advance_in && !state.held[0]
        |=> !alarm_match_flag_out[0]) else $error("weekday write left flag set");
    reassert_held_a: assert property (
        state.held[0] && alarm_unit_enable_in[0] && !time_advance_in |=> alarm_match_flag_out[0])
        else $error("flag not set again while match held");
    no_spurious_set_a: assert property (
        !alarm_match_flag_out[0] && !(alarm_unit_enable_in[0] && (time_advance_in ? match[0] : state.held[0]))
        |=> !alarm_match_flag_out[0]) else $error("flag set without match");
    hours_select_a: assert property (
        time_advance_in && alarm_unit_enable_in[0] && state.select[0] == SEL_HOURS
        && time_in.hours[HOURS_HI:0] == state.hours[0] |=> alarm_match_flag_out[0])
        else $error("hours match missed");
    // Guard only: software is not expected to program the reserved code
    reserved_select_a: assert property (
        state.select[0] == 3'h5 |-> !match[0]) else $error("reserved code matched");

    // Alarm 1 follows the same flag rules
    unit1_sets_flag_a: assert property (
        time_advance_in && match[1] && alarm_unit_enable_in[1] |=> alarm_match_flag_out[1])
        else $error("alarm 1 flag not set on match");
    unit1_clear_a: assert property (
        reg_write_in && kind == KIND_WEEKDAY && unit && !time_advance_in && !state.held[1]
        |=> !alarm_match_flag_out[1]) else $error("alarm 1 weekday write left flag set");
    unit1_disabled_a: assert property (
        !alarm_match_flag_out[1] && !alarm_unit_enable_in[1] |=> !alarm_match_flag_out[1])
        else $error("disabled alarm 1 set its flag");

    // Readback, mode and pin; the pin lags the flag by one register stage
    date_top_zero_a: assert property (
        reg_read_in && kind == KIND_DATE |=> reg_rdata_out[7:6] == 2'h0) else $error("date top bits not zero");
    mode_follows_a: assert property (
        1'b1 |=> alarm_mode_out == $past(!square_wave_enable_in && alarm_unit_enable_in != 2'h0))
        else $error("alarm mode does not follow controls");
    pin_polarity_a: assert property (
        !square_wave_enable_in && (state.flag & alarm_unit_enable_in) != 2'h0
        |=> multi_function_pin_oe_n_out == $past(state.polarity)) else $error("pin level wrong for polarity");
    pin_release_a: assert property (
        square_wave_enable_in || alarm_unit_enable_in == 2'h0 |=> multi_function_pin_oe_n_out && !alarm_mode_out)
        else $error("pin driven outside alarm mode");

    // Main scenarios seen at least once
    match_cover_c:  cover property (time_advance_in && match[0] && alarm_unit_enable_in[0]
        ##1 alarm_match_flag_out[0]);
    clear_cover_c:  cover property (alarm_match_flag_out[1] ##1 !alarm_match_flag_out[1]);
    pin_cover_c:    cover property (alarm_mode_out && !multi_function_pin_oe_n_out);
    all_cover_c:    cover property (state.select[1] == SEL_ALL && match[1]);
    held_cover_c:   cover property (state.held[1] && reg_write_in && kind == KIND_WEEKDAY && unit);

endmodule // rtc_alarm_match

//--- verif/host_model.sv
// Host-side model that turns bench requests into single-cycle register strobes
`timescale 1ns/1ns
module host_model
(
    // Clock and reset
    input  logic       clock_in,
    input  logic       rst_in,
    // Requests from the bench
    input  logic       go_in,
    input  logic       write_in,
    input  logic [7:0] addr_in,
    input  logic [7:0] data_in,
    // Register port of the device
    output logic       reg_write_out,
    output logic       reg_read_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out
);
    // One strobe per request; idle address and data lines toggle so a stale value never looks valid
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reg_write_out <= 1'b0;
            reg_read_out  <= 1'b0;
            reg_addr_out  <= 8'h00;
            reg_wdata_out <= 8'h00;
        end
        else
        begin
            reg_write_out <= go_in & write_in;
            reg_read_out  <= go_in & ~write_in;
            reg_addr_out  <= go_in ? addr_in : ~reg_addr_out;
            reg_wdata_out <= go_in ? data_in : ~reg_wdata_out;
        end
    end
endmodule // host_model

//--- verif/rtc_alarm_match_test.sv
// Self-checking bench for the two calendar alarms
`timescale 1ns/1ns
module rtc_alarm_match_test
    import alarm_match_pkg::*;
;
    logic        clock_in, rst_in, go, wr_sel, adv, sw, reg_write, reg_read, mode, pin, oe_n;
    logic [7:0]  addr, data, reg_addr, reg_wdata, rdata;
    logic [1:0]  en, flag;
    time_s       tm;
    alarm_ext_s  ext;
    int          num_errors, tests_run;
    logic [31:0] seed;
    logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7}; // Reserved 101 and 110 never used

    host_model host_u (.clock_in(clock_in), .rst_in(rst_in), .go_in(go), .write_in(wr_sel),
        .addr_in(addr), .data_in(data), .reg_write_out(reg_write), .reg_read_out(reg_read),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));
    rtc_alarm_match dut_u (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
        .reg_rdata_out(rdata), .time_advance_in(adv), .time_in(tm), .alarm0_ext_in(ext),
        .alarm1_ext_in(ext), .alarm_unit_enable_in(en), .square_wave_enable_in(sw),
        .alarm_match_flag_out(flag), .alarm_mode_out(mode), .multi_function_pin_out(pin),
        .multi_function_pin_oe_n_out(oe_n));

    // Free-running 250 MHz clock
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // Xorshift source, fixed start for repeatable runs
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected comparison result for a select code
    function automatic logic want(input logic [2:0] c, input logic [5:0] h, input logic [2:0] w,
                                  input logic [5:0] d);
        logic s, m, hh, ww, dd;
        s  = tm.seconds === ext.seconds;
        m  = tm.minutes === ext.minutes;
        hh = tm.hours[5:0] === h;
        ww = tm.weekday === w;
        dd = tm.date === d;
        case (c)
            3'h0: want = s;
            3'h1: want = m;
            3'h2: want = hh;
            3'h3: want = ww;
            3'h4: want = dd;
            3'h7: want = s & m & hh & ww & dd & (tm.month === ext.month);
            default: want = 1'b0;
        endcase
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request through the host model; returns once the device has taken it
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        go = 1'b1;
        wr_sel = w;
        addr = a;
        data = d;
        step(1);
        go = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        step(1);
        check(rdata, exp);
    endtask

    task automatic results();
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #40000;
        num_errors++;
        results();
    end

    // Main sequence
    initial
    begin
        logic [7:0] base;
        logic [5:0] h, d;
        logic [2:0] c, w;
        logic       u, p, a, em;
        seed = 32'hA4F0;
        {go, wr_sel, adv, sw, addr, data, en, tm, ext} = '0;
        num_errors = 0;
        tests_run = 0;
        rst_in = 1'b1;
        step(3);
        rst_in = 1'b0;
        // Reset values and an unmapped place
        foreach (codes[k])
        begin
            base = k[0] ? HOURS_ADDR1 : HOURS_ADDR0;
            if (k < 2)
            begin
                rd(base, 8'h00);
                rd(base + 8'h01, 8'h01);
                rd(base + 8'h02, 8'h01);
            end
        end
        rd(8'h10, 8'h00);
        check({6'h0, flag}, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            c = codes[i % 6];
            u = 1'(rnd());
            p = 1'(rnd());
            h = 6'(rnd());
            w = 3'(rnd() % 7 + 1); // Weekday 1..7
            d = {2'(rnd() % 4), 4'(rnd() % 10)}; // BCD date digits
            base = u ? HOURS_ADDR1 : HOURS_ADDR0;
            // Advance with the alarm off so no earlier match is held
            en = 2'b00;
            adv = 1'b1;
            step(1);
            adv = 1'b0;
            bus(1'b1, base, {2'b11, h});
            rd(base, {1'b0, tm.hours[6], h});
            bus(1'b1, base + 8'h02, {2'b11, d});
            rd(base + 8'h02, {2'b00, d});
            bus(1'b1, base + 8'h01, {p, c, 1'b1, w});
            rd(base + 8'h01, {p, c, 1'b0, w});
            tm = 35'({rnd(), rnd()});
            tm.hours[5:0] = h;
            tm.weekday = w;
            tm.date = d;
            ext = {tm.seconds, tm.minutes, tm.month};
            if (rnd() % 2)
                tm = tm ^ (35'h1 << (rnd() % 35));
            en[u] = 1'(rnd() % 4 != 0);
            sw = 1'(rnd() % 4 == 0);
            a = want(c, h, w, d) & en[u];
            em = ~sw & en[u];
            // Equal fields without an advance must not set the flag
            step(2);
            check({7'h0, flag[u]}, 8'h00);
            adv = 1'b1;
            step(1);
            adv = 1'b0;
            check({7'h0, flag[u]}, {7'h0, a});
            step(1);
            check({5'h0, mode, pin, oe_n}, {5'h0, em, 1'b0, ~(em & ~(p ? a : ~a))});
            if (a)
            begin
                bus(1'b1, base + 8'h01, {p, c, 1'b0, w});
                check({7'h0, flag[u]}, 8'h01);
            end
        end
        results();
    end
endmodule // rtc_alarm_match_test
